/* rtl/chan_if.sv */
// control and result signals between the sequencer and one integrating channel
`timescale 1ns/1ps
interface chan_if;
  logic        clr;
  logic        run;
  logic [15:0] count;
  modport ctrl (output clr, output run, input count);
  modport chan (input clr, input run, output count);
endinterface : chan_if

/* rtl/color_sensor_sequencer.sv */
// state machine, phase timing and result registers of the colour sensor
`timescale 1ns/1ps
module color_sensor_sequencer
  import color_seq_pkg::*;
#(
  parameter int STEP_CYCLES = color_seq_pkg::STEP_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  // serial bus engine side
  input  wire logic                         start_detect_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  input  wire logic [4:0]                   reg_addr_i,
  input  wire logic [7:0]                   reg_wdata_i,
  output logic      [7:0]                   reg_rdata_o,
  output logic                              reg_rvalid_o,
  // photodiode front end
  input  wire logic [color_seq_pkg::NUM_CHAN-1:0] light_pulse_i,
  output logic      [1:0]                   analog_gain_o,
  output logic                              integrating_o,
  output logic                              sleeping_o
);
  import color_seq_pkg::*;

  seq_state_t        state_reg;
  seq_state_t        state_next;
  logic [7:0]        enable_reg;
  logic [7:0]        itime_reg;
  logic [7:0]        wtime_reg;
  logic [7:0]        config_reg;
  logic [7:0]        control_reg;
  logic              valid_reg;
  logic [TICK_W-1:0] pre_reg;
  logic [11:0]       phase_reg;
  logic [11:0]       phase_len;
  logic [11:0]       wait_steps;
  logic [11:0]       adc_steps;
  logic              tick;
  logic              phase_done;
  logic              load;
  logic              load_reg;
  logic              clr_reg;
  logic              run_reg;
  logic [DATA_W-1:0] cnt_w    [NUM_CHAN];
  logic [DATA_W-1:0] data_reg [NUM_CHAN];
  logic [7:0]        shadow_reg;
  logic [1:0]        shadow_ch_reg;
  logic              power_on_bit;
  logic              conv_en;
  logic              wait_en;
  logic [2:0]        data_idx;
  logic [1:0]        rd_ch;

  assign power_on_bit     = enable_reg[EN_PON_BIT];
  assign conv_en = enable_reg[EN_CONV_BIT];
  assign wait_en = enable_reg[EN_WAIT_BIT];

  // channels
  chan_if chan [NUM_CHAN] ();
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      assign chan[g].clr = clr_reg;
      assign chan[g].run = run_reg;
      assign cnt_w[g]    = chan[g].count;
      light_integrator u_int (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .pulse_i (light_pulse_i[g]),
        .bus     (chan[g])
      );
    end
  endgenerate

  // phase lengths in 2.4 ms steps
  always_comb begin
    adc_steps  = STEP_BASE - {4'h0, itime_reg};
    wait_steps = STEP_BASE - {4'h0, wtime_reg};
    if (config_reg[CFG_LONG_BIT]) begin
      wait_steps = 12'(wait_steps * LONG_WAIT_MULT);
    end
    unique case (state_reg)
      ST_WAIT: phase_len = wait_steps;
      ST_INIT: phase_len = INIT_STEPS;
      ST_ADC:  phase_len = adc_steps;
      default: phase_len = INIT_STEPS;
    endcase
  end

  assign tick       = (pre_reg == TICK_W'(STEP_CYCLES - 1));
  assign phase_done = tick && (phase_reg == phase_len - 12'h001);
  assign load       = ce_i && (state_reg == ST_ADC) && phase_done;

  // state transitions
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_SLEEP: if (start_detect_i) state_next = ST_IDLE;
      ST_IDLE: begin
        if (!power_on_bit) begin
          state_next = ST_SLEEP;
        end else if (conv_en) begin
          state_next = wait_en ? ST_WAIT : ST_INIT;
        end
      end
      ST_WAIT: if (phase_done) state_next = ST_INIT;
      ST_INIT: if (phase_done) state_next = ST_ADC;
      ST_ADC:  if (phase_done) state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_SLEEP;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // step prescaler and phase counter restart on every state change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_reg   <= '0;
      phase_reg <= '0;
    end else if (ce_i) begin
      if (state_next != state_reg || state_reg == ST_SLEEP || state_reg == ST_IDLE) begin
        pre_reg   <= '0;
        phase_reg <= '0;
      end else if (tick) begin
        pre_reg   <= '0;
        phase_reg <= phase_reg + 12'h001;
      end else begin
        pre_reg <= pre_reg + TICK_W'(1);
      end
    end
  end

  // integrators cleared during init, all run together through the adc phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_reg       <= 1'b0;
      run_reg       <= 1'b0;
      sleeping_o    <= 1'b1;
      analog_gain_o <= 2'h0;
    end else if (ce_i) begin
      clr_reg       <= (state_next == ST_INIT);
      run_reg       <= (state_next == ST_ADC);
      sleeping_o    <= (state_next == ST_SLEEP);
      analog_gain_o <= control_reg[1:0];
    end
  end

  assign integrating_o = run_reg;

  // host register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_reg  <= ENABLE_RST;
      itime_reg   <= ITIME_RST;
      wtime_reg   <= WTIME_RST;
      config_reg  <= CONFIG_RST;
      control_reg <= CONTROL_RST;
    end else if (ce_i && reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_ENABLE:  enable_reg  <= reg_wdata_i;
        ADDR_ITIME:   itime_reg   <= reg_wdata_i;
        ADDR_WTIME:   wtime_reg   <= reg_wdata_i;
        ADDR_CONFIG:  config_reg  <= reg_wdata_i;
        ADDR_CONTROL: control_reg <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // the integrators still count on the last adc edge, so loading there would drop one pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_reg <= 1'b0;
    end else if (ce_i) begin
      load_reg <= load;
    end
  end

  // result registers: a new result wins over a clear of the valid flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_reg <= 1'b0;
      for (int i = 0; i < NUM_CHAN; i++) data_reg[i] <= '0;
    end else if (ce_i) begin
      if (load_reg) begin
        valid_reg <= 1'b1;
        for (int i = 0; i < NUM_CHAN; i++) data_reg[i] <= cnt_w[i];
      end else if (reg_wr_i && reg_addr_i == ADDR_ENABLE && !reg_wdata_i[EN_CONV_BIT]) begin
        valid_reg <= 1'b0;
      end
    end
  end

  assign data_idx = 3'(reg_addr_i - ADDR_DATA0);
  assign rd_ch    = data_idx[2:1];

  // reading a low byte freezes its high byte, so a two-byte read is never torn
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o   <= 8'h00;
      reg_rvalid_o  <= 1'b0;
      shadow_reg    <= 8'h00;
      shadow_ch_reg <= 2'h0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        if (reg_addr_i >= ADDR_DATA0 && reg_addr_i <= ADDR_DATA_END) begin
          if (!data_idx[0]) begin
            reg_rdata_o   <= data_reg[rd_ch][7:0];
            shadow_reg    <= data_reg[rd_ch][15:8];
            shadow_ch_reg <= rd_ch;
          end else if (shadow_ch_reg == rd_ch) begin
            reg_rdata_o <= shadow_reg;
          end else begin
            reg_rdata_o <= data_reg[rd_ch][15:8];
          end
        end else begin
          unique case (reg_addr_i)
            ADDR_ENABLE:  reg_rdata_o <= enable_reg;
            ADDR_ITIME:   reg_rdata_o <= itime_reg;
            ADDR_WTIME:   reg_rdata_o <= wtime_reg;
            ADDR_CONFIG:  reg_rdata_o <= config_reg;
            ADDR_CONTROL: reg_rdata_o <= control_reg;
            ADDR_ID:      reg_rdata_o <= DEVICE_ID;
            ADDR_STATUS:  reg_rdata_o <= {7'h00, valid_reg};
            default:      reg_rdata_o <= 8'h00;
          endcase
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_to_sleep: assert property ($past(rst_i) |-> state_reg == ST_SLEEP)
    else $error("not asleep after reset");
  a_wake_on_start: assert property (ce_i && state_reg == ST_SLEEP && start_detect_i
    |=> state_reg == ST_IDLE)
    else $error("start condition did not wake the machine");
  a_enable_write: assert property (ce_i && reg_wr_i && reg_addr_i == ADDR_ENABLE
    |=> power_on_bit == $past(reg_wdata_i[0]))
    else $error("power-on bit not taken from bit 0");
  a_idle_sleeps: assert property (ce_i && state_reg == ST_IDLE && !power_on_bit
    |=> state_reg == ST_SLEEP)
    else $error("idle without power-on did not sleep");
  a_idle_holds: assert property (ce_i && state_reg == ST_IDLE && power_on_bit && !conv_en
    |=> state_reg == ST_IDLE)
    else $error("idle left without conversion enable");
  a_cycle_restart: assert property (ce_i && state_reg == ST_IDLE && power_on_bit && conv_en
    |=> state_reg == ($past(wait_en) ? ST_WAIT : ST_INIT))
    else $error("cycle did not restart from idle");
  a_wait_then_init: assert property (ce_i && state_reg == ST_WAIT && phase_done
    |=> state_reg == ST_INIT ##0 clr_reg)
    else $error("wait did not lead to init");
  a_init_one_step: assert property (ce_i && state_reg == ST_INIT && tick
    |=> state_reg == ST_ADC && run_reg)
    else $error("init did not last one step");
  a_adc_length: assert property (ce_i && state_reg == ST_ADC && tick
    && phase_reg == adc_steps - 12'h001 |=> state_reg == ST_IDLE && !run_reg)
    else $error("integration length wrong");
  a_data_load: assert property (load_reg |=> data_reg[0] == $past(cnt_w[0])
    && data_reg[3] == $past(cnt_w[3]) && valid_reg)
    else $error("results not loaded at conversion end");
  a_data_hold: assert property (!load_reg |=> $stable(data_reg[1]) && $stable(data_reg[2]))
    else $error("data changed without a completed conversion");
  a_long_wait: assert property (state_reg == ST_WAIT && config_reg[CFG_LONG_BIT]
    |-> phase_len == 12'((STEP_BASE - {4'h0, wtime_reg}) * LONG_WAIT_MULT))
    else $error("long wait not twelve times");

  c_wait_path:   cover property (state_reg == ST_WAIT ##1 state_reg == ST_INIT);
  c_direct_conv: cover property (state_reg == ST_IDLE ##1 state_reg == ST_INIT);
  c_back_sleep:  cover property (state_reg == ST_IDLE ##1 state_reg == ST_SLEEP);
  c_result_load: cover property (load);
endmodule : color_sensor_sequencer

/* rtl/color_seq_pkg.sv */
// constants, register map and state type of the colour sensor sequencer
package color_seq_pkg;
  // register map
  localparam logic [4:0] ADDR_ENABLE  = 5'h00;
  localparam logic [4:0] ADDR_ITIME   = 5'h01;
  localparam logic [4:0] ADDR_WTIME   = 5'h03;
  localparam logic [4:0] ADDR_CONFIG  = 5'h0d;
  localparam logic [4:0] ADDR_CONTROL = 5'h0f;
  localparam logic [4:0] ADDR_ID      = 5'h12;
  localparam logic [4:0] ADDR_STATUS  = 5'h13;
  localparam logic [4:0] ADDR_DATA0   = 5'h14;
  localparam logic [4:0] ADDR_DATA_END = 5'h1b;
  // field positions
  localparam int EN_PON_BIT     = 0;
  localparam int EN_CONV_BIT    = 1;
  localparam int EN_WAIT_BIT    = 3;
  localparam int CFG_LONG_BIT   = 1;
  localparam int STAT_VALID_BIT = 0;
  // reset values
  localparam logic [7:0] ENABLE_RST  = 8'h00;
  localparam logic [7:0] ITIME_RST   = 8'hff;
  localparam logic [7:0] WTIME_RST   = 8'hff;
  localparam logic [7:0] CONFIG_RST  = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  // identity value is arbitrary
  localparam logic [7:0] DEVICE_ID   = 8'h5a;
  // timing
  localparam int         CLK_PERIOD_NS   = 5;
  localparam int         STEP_TIME_NS    = 2400000;
  localparam int         STEP_CYCLES_DEF = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         TICK_W          = 20;
  localparam logic [11:0] STEP_BASE      = 12'h100;
  localparam logic [11:0] LONG_WAIT_MULT = 12'h00c;
  localparam logic [11:0] INIT_STEPS     = 12'h001;
  // channels: clear, red, green, blue
  localparam int NUM_CHAN = 4;
  localparam int DATA_W   = 16;

  typedef enum logic [2:0] {ST_SLEEP, ST_IDLE, ST_WAIT, ST_INIT, ST_ADC} seq_state_t;
endpackage : color_seq_pkg

/* rtl/light_integrator.sv */
// one integrating light channel: counts photodiode charge pulses while running
`timescale 1ns/1ps
module light_integrator (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // photodiode front end
  input  wire logic pulse_i,
  // sequencer side
  chan_if.chan      bus
);
  import color_seq_pkg::*;

  logic [DATA_W-1:0] count_reg;

  // saturate rather than wrap so an overflow reads as full scale
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else if (ce_i) begin
      if (bus.clr) begin
        count_reg <= '0;
      end else if (bus.run && pulse_i && count_reg != '1) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  assign bus.count = count_reg;
endmodule : light_integrator

/* verification/color_sensor_sequencer_tb_top.sv */
// self-checking bench for the colour sensor sequencer
`timescale 1ns/1ps
module color_sensor_sequencer_tb_top;
  import color_seq_pkg::*;
  // short step keeps the run brief; the adc, wait, init and data expectations scale with it, the one idle cycle does not
  localparam int SC = 4;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       ce    = 1'b1;
  logic       start, wr, rd, rvalid, integ, sleep_s;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, rb;
  logic [3:0] light = 4'h0;
  logic [1:0] gain;
  logic [31:0] r;
  int         k;
  int         mismatches = 0;
  int         check_count = 0;
  int         seed = 36297;
  logic [4:0] ra [8] = '{ADDR_ENABLE, ADDR_ITIME, ADDR_WTIME, ADDR_CONFIG, ADDR_CONTROL,
                         ADDR_STATUS, ADDR_DATA0, 5'h02};
  logic [7:0] re [8] = '{ENABLE_RST, ITIME_RST, WTIME_RST, CONFIG_RST, CONTROL_RST,
                         8'h00, 8'h00, 8'h00};

  always #2.5 clk_i = ~clk_i;

  host_model host_u (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .start_o(start),
                     .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

  color_sensor_sequencer #(.STEP_CYCLES(SC)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .start_detect_i(start), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .light_pulse_i(light), .analog_gain_o(gain),
    .integrating_o(integ), .sleeping_o(sleep_s));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string w);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk_byte

  task automatic chk_num(input int got, input int exp, input string w);
    check_count++;
    if (got != exp) begin
      mismatches++;
      $display("MISMATCH %0t %s cycles %0d exp %0d", $time, w, got, exp);
    end
  endtask : chk_num

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e, input string w);
    host_u.rd(a, rb);
    chk_byte(rb, e, w);
  endtask : rd_chk

  // waits a bounded time for the sleep flag to reach v
  task automatic sleep_is(input logic v, input int n);
    int i;
    i = 0;
    while (sleep_s !== v && i < n) begin
      @(negedge clk_i);
      i++;
    end
    chk_byte({7'h0, sleep_s}, {7'h0, v}, "sleep flag");
  endtask : sleep_is

  // counts cycles while the integrating flag stays at v
  task automatic span(input logic v, output int n);
    n = 0;
    while (integ === v && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
  endtask : span

  task automatic run_case(input logic [7:0] it, input logic wen, input logic lng,
                          input logic [3:0] mask, input logic [1:0] g);
    int hi, lo, q, w;
    logic [15:0] e;
    // drop conversion enable and let the running cycle drain into idle
    host_u.wr(ADDR_ENABLE, 8'h01);
    q = 0;
    for (int i = 0; i < 3000 && q < 100; i++) begin
      @(negedge clk_i);
      q = integ ? 0 : q + 1;
    end
    light = mask;
    w = wen ? SC * (lng ? 12 : 1) : 0;
    host_u.wr(ADDR_ITIME, it);
    host_u.wr(ADDR_WTIME, 8'hff);
    host_u.wr(ADDR_CONFIG, {6'h0, lng, 1'b0});
    host_u.wr(ADDR_CONTROL, {6'h0, g});
    host_u.wr(ADDR_ENABLE, {4'h0, wen, 3'b011});
    span(1'b0, q);
    span(1'b1, hi);
    span(1'b0, lo);
    chk_num(hi, (256 - it) * SC, "adc length");
    chk_num(lo, 1 + SC + w, "idle wait init");
    chk_byte({6'h0, gain}, {6'h0, g}, "gain");
    for (int c = 0; c < 4; c++) begin
      e = mask[c] ? 16'((256 - it) * SC) : 16'h0;
      rd_chk(5'(ADDR_DATA0 + 2 * c), e[7:0], "data low");
      rd_chk(5'(ADDR_DATA0 + 2 * c + 1), e[15:8], "data high");
    end
    host_u.rd(ADDR_STATUS, rb);
    chk_byte({7'h0, rb[STAT_VALID_BIT]}, 8'h01, "valid");
  endtask : run_case

  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    chk_byte({7'h0, sleep_s}, 8'h01, "sleep after reset");
    chk_byte({6'h0, gain}, 8'h00, "gain after reset");
    for (int i = 0; i < 8; i++) rd_chk(ra[i], re[i], "reset value");
    rd_chk(ADDR_ID, DEVICE_ID, "device id");
    host_u.wr(ADDR_STATUS, 8'hff);
    rd_chk(ADDR_STATUS, 8'h00, "read-only status");
    host_u.st();
    sleep_is(1'b0, 4);
    sleep_is(1'b1, 4);
    host_u.wr(ADDR_ENABLE, 8'h01);
    rd_chk(ADDR_ENABLE, 8'h01, "power bit");
    host_u.st();
    sleep_is(1'b0, 4);
    repeat (40) @(negedge clk_i);
    chk_byte({6'h0, sleep_s, integ}, 8'h00, "idle hold");
    // a write while the clock enable is low must leave everything as it was
    ce = 1'b0;
    host_u.wr(ADDR_ENABLE, 8'h00);
    @(negedge clk_i);
    ce = 1'b1;
    chk_byte({6'h0, sleep_s, integ}, 8'h00, "frozen hold");
    rd_chk(ADDR_ENABLE, 8'h01, "frozen write");
    run_case(8'hfe, 1'b0, 1'b0, 4'ha, 2'h1);
    run_case(8'hfd, 1'b1, 1'b0, 4'h5, 2'h2);
    run_case(8'hff, 1'b1, 1'b1, 4'hf, 2'h3);
    run_case(8'hc0, 1'b0, 1'b0, 4'h6, 2'h0);
    repeat (3) begin
      r = $random(seed);
      run_case(8'hf8 | {5'h0, r[2:0]}, r[3], r[4], r[8:5], r[10:9]);
    end
    host_u.wr(ADDR_ENABLE, 8'h00);
    sleep_is(1'b1, 400);
    stop_test();
  end

  initial begin
    #(20000 * 5);
    mismatches++;
    $display("MISMATCH %0t watchdog expired", $time);
    stop_test();
  end
endmodule : color_sensor_sequencer_tb_top

/* verification/host_model.sv */
// register master model standing in for the serial bus engine host
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic       clk_i,
  // answers from the device
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  // requests to the device
  output logic            start_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic [4:0]      addr_o,
  output logic [7:0]      wdata_o
);
  initial begin
    {start_o, wr_o, rd_o, addr_o, wdata_o} = '0;
  end

  // one-cycle start pulse, as the bus engine reports a start condition
  task automatic st;
    @(negedge clk_i);
    start_o = 1'b1;
    @(negedge clk_i);
    start_o = 1'b0;
  endtask : st

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clk_i);
    wr_o = 1'b0;
  endtask : wr

  // data is taken when the valid pulse shows; a missing pulse yields unknowns
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk_i);
    {rd_o, addr_o} = {1'b1, a};
    @(negedge clk_i);
    rd_o = 1'b0;
    for (int i = 0; i < 4 && rvalid_i !== 1'b1; i++) @(negedge clk_i);
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask : rd
endmodule : host_model
